/* File: core/clock_safeguard_reset_control.sv */
// Purpose: Clock source selection, safeguard filter and reset sequencing
// Assumes: Main oscillator sampled as a level; 100 MHz CLOCK
// Notes: Internal clock is given as a one-cycle tick enable, not a clock
// What this block does
// - With safeguard on, backup oscillator starts one backup period after missing edge.
// - Backup oscillator is usable only when the safeguard option is selected.
// - At power-on, backup oscillator clocks the stabilisation counter until main runs.
// - Backup oscillator stops, main clock returns, once main oscillator runs.
// - Oscillator control bit 0 set stops main oscillator; clear lets it run.
// - Safeguard removes clock cycles so internal clock stays below ceiling.
// - Safeguard and backup access set by a fixed option, not software.
// - Reset comes from reset pin low, power-on, or watchdog timeout.
// - Reset pin is active low; reset holds while pin is low.
// - Internal reset is a stretched version, so short pulses fully reset.
// - Reset in run or wait halts program, pulls ports up, restarts oscillator.
// - Reset in stop starts oscillator; init waits for pin high and delay.
// - Internal reset releases 2048 internal clock cycles after external release.
// - Power-on holds reset; delay count starts once oscillator operates.
// - Watchdog end-of-count resets, reloads watchdog, restarts like pin reset.
// - Leaving reset clears stack and loads program counter from vector 0FFEh.
// - Core starts in NMI mode; return from interrupt restores normal mode.
// - Clearing disable bit or any reset restarts the main oscillator.
//
// Register access over AHB-Lite is this design's own decision.
`default_nettype none
module clock_safeguard_reset_control
    import clk_rst_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic SAFEGUARD_OPTION,
    input wire logic MAIN_OSC_IN,
    input wire logic RESET_PIN_N,
    input wire logic POWER_ON,
    input wire logic WATCHDOG_EXPIRED,
    input wire logic RETURN_FROM_INTERRUPT,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HSEL,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    output logic MAIN_OSC_ENABLE,
    output logic BACKUP_OSC_ENABLE,
    output logic INT_CLOCK_TICK,
    output logic CORE_RESET,
    output logic PORTS_PULLUP_INPUT,
    output logic WATCHDOG_RELOAD,
    output logic STACK_CLEAR,
    output logic PC_LOAD,
    output logic [11:0] PC_LOAD_VALUE,
    output logic NMI_MODE
);
    // Synchronised pins
    logic main_osc_s;
    logic reset_pin_s;
    logic power_on_s;
    logic option_s;

    clk_sync2 u_sync_osc (
        .clk(CLOCK),
        .rst_n(RSTN),
        .async_in(MAIN_OSC_IN),
        .rst_val(1'b0),
        .sync_out(main_osc_s)
    );
    clk_sync2 u_sync_pin (
        .clk(CLOCK),
        .rst_n(RSTN),
        .async_in(RESET_PIN_N),
        .rst_val(1'b0),
        .sync_out(reset_pin_s)
    );
    clk_sync2 u_sync_por (
        .clk(CLOCK),
        .rst_n(RSTN),
        .async_in(POWER_ON),
        .rst_val(1'b0),
        .sync_out(power_on_s)
    );
    clk_sync2 u_sync_opt (
        .clk(CLOCK),
        .rst_n(RSTN),
        .async_in(SAFEGUARD_OPTION),
        .rst_val(1'b0),
        .sync_out(option_s)
    );

    // Registers
    logic main_osc_disable_q;
    logic safeguard_q;
    logic opt_latched_q;
    logic [1:0] opt_wait_q;
    logic osc_prev_q;
    logic [3:0] miss_cnt_q;
    logic main_fail_q;
    logic [5:0] backup_div_q;
    logic backup_arm_q;
    logic backup_run_q;
    logic backup_tick_q;
    logic [2:0] gap_q;
    logic [11:0] stab_q;
    rst_state_type state_q;
    rst_state_type state_d;
    logic nmi_q;
    logic core_reset_q;
    logic leave_q;

    // Option caught once after release, so software cannot change it;
    // waits two edges so the synchroniser shows the pin, not its reset
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            opt_wait_q <= 2'h0;
            opt_latched_q <= 1'b0;
            safeguard_q <= 1'b0;
        end else begin
            opt_wait_q <= {opt_wait_q[0], 1'b1};
            if (opt_wait_q[1] && !opt_latched_q) begin
                opt_latched_q <= 1'b1;
                safeguard_q <= option_s;
            end
        end
    end

    // Main oscillator edge detect on the synchronised level
    wire main_edge = main_osc_s != osc_prev_q;
    wire miss_over = miss_cnt_q == MISS_LIMIT;
    wire main_running = !main_fail_q && !main_osc_disable_q;

    // Timeout counter cleared by every main edge
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            osc_prev_q <= 1'b0;
            miss_cnt_q <= 4'h0;
            main_fail_q <= 1'b1;
        end else begin
            osc_prev_q <= main_osc_s;
            if (main_edge) begin
                miss_cnt_q <= 4'h0;
                main_fail_q <= 1'b0;
            end else if (miss_over) begin
                main_fail_q <= 1'b1;
            end else begin
                miss_cnt_q <= miss_cnt_q + 4'h1;
            end
        end
    end

    // Backup oscillator: armed on failure, runs one period later
    wire backup_wanted = safeguard_q && !main_running;
    wire backup_wrap = backup_div_q == BACKUP_HALF;

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            backup_div_q <= 6'h00;
            backup_arm_q <= 1'b0;
            backup_run_q <= 1'b0;
            backup_tick_q <= 1'b0;
        end else begin
            backup_tick_q <= backup_run_q && backup_wrap;
            if (!backup_wanted) begin
                backup_div_q <= 6'h00;
                backup_arm_q <= 1'b0;
                backup_run_q <= 1'b0;
            end else begin
                backup_div_q <= backup_wrap ? 6'h00 : backup_div_q + 6'h01;
                backup_arm_q <= 1'b1;
                if (backup_arm_q && backup_wrap) begin
                    backup_run_q <= 1'b1;
                end
            end
        end
    end

    // Safeguard spacing filter on main edges; drops over-fast cycles
    wire gap_ok = gap_q == SAFEGUARD_GAP;
    wire main_tick = main_running && main_edge && main_osc_s;
    wire pass_main = main_tick && (!safeguard_q || gap_ok);

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            gap_q <= 3'h0;
        end else if (pass_main) begin
            gap_q <= 3'h0;
        end else if (!gap_ok) begin
            gap_q <= gap_q + 3'h1;
        end
    end

    // Internal clock from main, or from backup when allowed
    wire int_tick = pass_main || (backup_run_q && backup_tick_q);

    // Reset sources merged; pin and watchdog restart identically
    wire reset_req = !reset_pin_s || power_on_s || WATCHDOG_EXPIRED;
    wire osc_going = main_running || backup_run_q;
    wire stab_done = stab_q == STAB_LAST;

    always_comb begin
        state_d = state_q;
        case (state_q)
            RST_HOLD: begin
                if (!reset_req) begin
                    state_d = RST_WAIT_OSC;
                end
            end
            RST_WAIT_OSC: begin
                if (reset_req) begin
                    state_d = RST_HOLD;
                end else if (osc_going) begin
                    state_d = RST_STRETCH;
                end
            end
            RST_STRETCH: begin
                if (reset_req) begin
                    state_d = RST_HOLD;
                end else if (int_tick && stab_done) begin
                    state_d = RST_RUN;
                end
            end
            RST_RUN: begin
                if (reset_req) begin
                    state_d = RST_HOLD;
                end
            end
            default: state_d = RST_HOLD;
        endcase
    end

    // Stabilisation counter counts internal clock ticks only
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= RST_HOLD;
            stab_q <= 12'h000;
        end else begin
            state_q <= state_d;
            if (state_q != RST_STRETCH) begin
                stab_q <= 12'h000;
            end else if (int_tick && !stab_done) begin
                stab_q <= stab_q + 12'h001;
            end
        end
    end

    wire leaving = state_q == RST_STRETCH && state_d == RST_RUN;

    // Core reset level, vector load pulse and NMI mode
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            core_reset_q <= 1'b1;
            leave_q <= 1'b0;
            nmi_q <= 1'b1;
        end else begin
            core_reset_q <= state_d != RST_RUN;
            leave_q <= leaving;
            if (state_d != RST_RUN) begin
                nmi_q <= 1'b1;
            end else if (RETURN_FROM_INTERRUPT) begin
                nmi_q <= 1'b0;
            end
        end
    end

    // Bus address phase capture
    logic wr_pend_q;
    logic [7:0] wr_idx_q;
    logic [31:0] rdata_q;
    wire take = HSEL && HREADY && HTRANS[1];
    wire [7:0] idx = HADDR[9:2];
    wire hit_osc = idx == OSC_CTRL_IDX;
    wire hit_stat = idx == OPT_STAT_IDX;
    wire [31:0] osc_word = {31'h0, main_osc_disable_q};
    wire [31:0] stat_word = {27'h0, safeguard_q, nmi_q, core_reset_q,
                             main_running, backup_run_q};
    wire [31:0] rd_sel = hit_osc ? osc_word : hit_stat ? stat_word : 32'h0;

    // Writes land in the data phase; reset restores the main oscillator
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 8'h00;
            rdata_q <= 32'h0;
            main_osc_disable_q <= OSC_CTRL_RESET[MAIN_OSC_DISABLE_BIT];
        end else begin
            wr_pend_q <= take && HWRITE;
            if (take) begin
                wr_idx_q <= idx;
                rdata_q <= rd_sel;
            end
            if (core_reset_q) begin
                main_osc_disable_q <= 1'b0;
            end else if (wr_pend_q && wr_idx_q == OSC_CTRL_IDX) begin
                // Upper bits ignored; software keeps them zero
                main_osc_disable_q <= HWDATA[MAIN_OSC_DISABLE_BIT];
            end
        end
    end

    assign HRDATA = rdata_q;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    // Oscillator stopped only by the disable bit, which core reset clears one cycle later
    assign MAIN_OSC_ENABLE = !main_osc_disable_q;
    assign BACKUP_OSC_ENABLE = backup_run_q;
    assign INT_CLOCK_TICK = int_tick;
    assign CORE_RESET = core_reset_q;
    assign PORTS_PULLUP_INPUT = core_reset_q;
    assign WATCHDOG_RELOAD = core_reset_q;
    assign STACK_CLEAR = leave_q;
    assign PC_LOAD = leave_q;
    assign PC_LOAD_VALUE = RESET_VECTOR;
    assign NMI_MODE = nmi_q;
endmodule : clock_safeguard_reset_control
`default_nettype wire

/* File: core/clk_rst_pkg.sv */
// Purpose: Shared constants for the clock safeguard and reset control block
// Assumes: 100 MHz CLOCK, AHB-Lite register access, 32-bit data
// Notes: Printed offset 0xdb is not word aligned, so it is an index
package clk_rst_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] OSC_CTRL_IDX = 8'hdb;
    localparam logic [7:0] OPT_STAT_IDX = 8'he0;
    // Field positions
    localparam int MAIN_OSC_DISABLE_BIT = 0;
    localparam int ST_BACKUP_BIT = 0;
    localparam int ST_MAIN_OK_BIT = 1;
    localparam int ST_RESET_BIT = 2;
    localparam int ST_NMI_BIT = 3;
    localparam int ST_SAFEGUARD_BIT = 4;
    // Reset values
    localparam logic [7:0] OSC_CTRL_RESET = 8'h00;
    localparam logic [11:0] RESET_VECTOR = 12'hffe;
    // Timing counts; the stabilisation delay is in internal clock cycles
    localparam int STAB_CYCLES = 2048;
    localparam logic [11:0] STAB_LAST = 12'(STAB_CYCLES - 1);
    // Missing-edge timeout in system cycles without a main edge
    localparam logic [3:0] MISS_LIMIT = 4'hf;
    // Last count of the backup oscillator period, in system clock cycles
    localparam logic [5:0] BACKUP_HALF = 6'h3f;
    // Idle cycles required after each internal clock tick under the safeguard
    localparam logic [2:0] SAFEGUARD_GAP = 3'h3;
    typedef enum {
        RST_HOLD,
        RST_WAIT_OSC,
        RST_STRETCH,
        RST_RUN
    } rst_state_type;
endpackage : clk_rst_pkg

/* File: core/clk_sync2.sv */
// Purpose: Two-flop synchroniser for asynchronous level inputs
// Assumes: Single clock domain on CLOCK
// Notes: First stage feeds only the second stage
`default_nettype none
module clk_sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    input wire logic rst_val,
    output logic sync_out
);
    logic meta_q;
    logic stage_q;

    // Flops clear to zero; the rst_val port sets the reset value through the output XOR
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            stage_q <= 1'b0;
        end else begin
            meta_q <= async_in ^ rst_val;
            stage_q <= meta_q;
        end
    end

    assign sync_out = stage_q ^ rst_val;
endmodule : clk_sync2
`default_nettype wire

/* File: tb/reset_checker.sv */
// Purpose: Assertions on reset sequencing and clock selection ports
// Assumes: One CLOCK domain, RSTN asynchronous and active low
// Notes: Bound into the block; watches its clock and reset outputs, not the bus ones, plus its option, reset pin and return inputs
`default_nettype none
module reset_checker (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic SAFEGUARD_OPTION,
    input wire logic RESET_PIN_N,
    input wire logic RETURN_FROM_INTERRUPT,
    input wire logic MAIN_OSC_ENABLE,
    input wire logic BACKUP_OSC_ENABLE,
    input wire logic INT_CLOCK_TICK,
    input wire logic CORE_RESET,
    input wire logic PORTS_PULLUP_INPUT,
    input wire logic WATCHDOG_RELOAD,
    input wire logic STACK_CLEAR,
    input wire logic PC_LOAD,
    input wire logic [11:0] PC_LOAD_VALUE,
    input wire logic NMI_MODE
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RSTN);
    // Start of code: vector load, stack clear, NMI mode, all in one cycle
    sequence vec_load_s;
        PC_LOAD && STACK_CLEAR && NMI_MODE && PC_LOAD_VALUE == 12'hffe;
    endsequence
    // Backup must come up within miss timeout plus one backup period
    sequence backup_up_s;
        ##[1:120] BACKUP_OSC_ENABLE;
    endsequence
    a_leave_vector: assert property (
        $fell(CORE_RESET) |-> vec_load_s ##1 !PC_LOAD)
        else $error("core left reset without vector load");
    a_load_cause: assert property (PC_LOAD |-> $fell(CORE_RESET))
        else $error("vector load outside reset exit");
    a_reset_outputs: assert property (
        PORTS_PULLUP_INPUT == CORE_RESET && WATCHDOG_RELOAD == CORE_RESET)
        else $error("pull-ups or watchdog reload not following reset");
    a_pin_holds: assert property (!RESET_PIN_N [*6] |-> CORE_RESET)
        else $error("core running while reset pin low");
    a_osc_restart: assert property (
        CORE_RESET [*3] |-> MAIN_OSC_ENABLE)
        else $error("main oscillator not restarted by reset");
    a_no_backup: assert property (
        !SAFEGUARD_OPTION |-> !BACKUP_OSC_ENABLE)
        else $error("backup running without safeguard");
    a_tick_gap: assert property (
        SAFEGUARD_OPTION && INT_CLOCK_TICK |=> !INT_CLOCK_TICK [*3])
        else $error("internal ticks closer than safeguard limit");
    a_backup_up: assert property (
        SAFEGUARD_OPTION && $fell(MAIN_OSC_ENABLE) |-> backup_up_s)
        else $error("backup did not start after main stopped");
    a_backup_down: assert property (
        $rose(MAIN_OSC_ENABLE) && !CORE_RESET |-> ##[1:120] !BACKUP_OSC_ENABLE)
        else $error("backup still running after main restart");
    a_nmi_clear: assert property (
        RETURN_FROM_INTERRUPT && !CORE_RESET |=> !NMI_MODE)
        else $error("return from interrupt kept NMI mode");
endmodule : reset_checker
bind clock_safeguard_reset_control reset_checker chk (
    .CLOCK, .RSTN, .SAFEGUARD_OPTION, .RESET_PIN_N, .RETURN_FROM_INTERRUPT,
    .MAIN_OSC_ENABLE, .BACKUP_OSC_ENABLE, .INT_CLOCK_TICK, .CORE_RESET,
    .PORTS_PULLUP_INPUT, .WATCHDOG_RELOAD, .STACK_CLEAR, .PC_LOAD,
    .PC_LOAD_VALUE, .NMI_MODE
);
`default_nettype wire

/* File: tb/osc_partner.sv */
// Purpose: Main crystal oscillator and external reset source model
// Assumes: Crystal runs only while powered and allowed by the block
// Notes: Reset pin has a pull-up, so it reads high when released
`default_nettype none
module osc_partner (
    input wire logic clk,
    input wire logic powered,
    input wire logic allow,
    input wire logic pull_low,
    input wire logic fast,
    output logic osc,
    output logic pin_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase_q = 2'h0;
    logic osc_q = 1'b0;
    // Eight-cycle period; a stopped crystal holds its line low
    // Fast mode toggles every cycle to play spikes on the crystal line
    always_ff @(posedge clk) begin
        phase_q <= phase_q + 2'h1;
        if (!(powered && allow)) begin
            osc_q <= 1'b0;
        end else if (fast || phase_q == 2'h3) begin
            osc_q <= ~osc_q;
        end
    end
    assign osc = osc_q;
    assign pin_n = !pull_low;
endmodule : osc_partner
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for clock safeguard and reset control
// Assumes: 100 MHz CLOCK, safeguard option fitted until the last scenario
// Notes: Each reset costs about 16k cycles of stretch at 8-cycle ticks
`default_nettype none
module testbench import clk_rst_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLOCK = 1'b0;
    logic RSTN = 1'b0;
    logic POWER_ON = 1'b1;
    logic WATCHDOG_EXPIRED = 1'b0;
    logic RETURN_FROM_INTERRUPT = 1'b0;
    logic pull_low = 1'b0;
    logic osc_power = 1'b0;
    logic option = 1'b1;
    logic fast = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    logic [31:0] HRDATA;
    logic [11:0] PC_LOAD_VALUE;
    logic HREADYOUT, HRESP, MAIN_OSC_ENABLE, BACKUP_OSC_ENABLE, NMI_MODE;
    logic INT_CLOCK_TICK, CORE_RESET, PORTS_PULLUP_INPUT, WATCHDOG_RELOAD;
    logic STACK_CLEAR, PC_LOAD, MAIN_OSC_IN, RESET_PIN_N;
    int n_mismatch = 0;
    int cmp_count = 0;

    clock_safeguard_reset_control dut (
        .CLOCK, .RSTN, .SAFEGUARD_OPTION(option), .MAIN_OSC_IN, .RESET_PIN_N,
        .POWER_ON, .WATCHDOG_EXPIRED, .RETURN_FROM_INTERRUPT, .HADDR, .HTRANS,
        .HWRITE, .HSIZE(3'h2), .HSEL(1'b1), .HREADY(HREADYOUT), .HWDATA,
        .HRDATA, .HREADYOUT, .HRESP, .MAIN_OSC_ENABLE, .BACKUP_OSC_ENABLE,
        .INT_CLOCK_TICK, .CORE_RESET, .PORTS_PULLUP_INPUT, .WATCHDOG_RELOAD,
        .STACK_CLEAR, .PC_LOAD, .PC_LOAD_VALUE, .NMI_MODE
    );
    osc_partner partner (
        .clk(CLOCK), .powered(osc_power), .allow(MAIN_OSC_ENABLE),
        .fast(fast),
        .pull_low(pull_low), .osc(MAIN_OSC_IN), .pin_n(RESET_PIN_N)
    );

    initial begin
        forever #5 CLOCK = ~CLOCK;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask : step

    // Single word transfer; the slave's ready ends each phase
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge CLOCK);
        HADDR <= {22'h0, idx, 2'h0};
        HTRANS <= 2'h2;
        HWRITE <= wr;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
        check(32'(HRESP), 32'h0, "error response");
    endtask : bus

    // Short request, then count ticks of the stretch until the core starts
    task automatic run_reset(input int kind, input int late);
        int ticks;
        ticks = 0;
        @(posedge CLOCK);
        pull_low <= (kind == 0);
        WATCHDOG_EXPIRED <= (kind == 1);
        POWER_ON <= (kind == 2);
        step(6);
        check(32'(CORE_RESET & NMI_MODE), 32'h1, "reset not entered");
        check(32'(PORTS_PULLUP_INPUT), 32'h1, "ports not pulled up");
        @(posedge CLOCK);
        {pull_low, WATCHDOG_EXPIRED, POWER_ON} <= 3'h0;
        // Backup ticks before the crystal wakes count towards the delay
        repeat (late) begin
            step(1);
            ticks += INT_CLOCK_TICK;
        end
        if (late > 0) begin
            check(32'(CORE_RESET), 32'h1, "ran before oscillator");
            check(32'(BACKUP_OSC_ENABLE), 32'h1, "no early backup");
            osc_power <= 1'b1;
        end
        forever begin
            step(1);
            if (CORE_RESET !== 1'b1) break;
            ticks += INT_CLOCK_TICK;
        end
        check(32'(ticks >= STAB_CYCLES), 32'h1, "delay short");
        check(32'(ticks <= STAB_CYCLES + 1), 32'h1, "delay long");
        check(32'(STACK_CLEAR & PC_LOAD), 32'h1, "no vector load");
        check(32'(PC_LOAD_VALUE), 32'hffe, "reset vector");
        check(32'(NMI_MODE), 32'h1, "start mode");
        check(32'(MAIN_OSC_ENABLE), 32'h1, "main off at start");
        @(posedge CLOCK);
        RETURN_FROM_INTERRUPT <= 1'b1;
        @(posedge CLOCK);
        RETURN_FROM_INTERRUPT <= 1'b0;
        step(1);
        check(32'(NMI_MODE | PC_LOAD), 32'h0, "normal mode");
    endtask : run_reset

    // Stop main by software, fall back to backup, then return
    task automatic osc_switch();
        logic [31:0] rd;
        bus(1'b0, OSC_CTRL_IDX, 32'h0, rd);
        check(rd, 32'h0, "control reset value");
        bus(1'b1, OSC_CTRL_IDX, 32'h1, rd);
        step(2);
        check(32'(MAIN_OSC_ENABLE), 32'h0, "main not stopped");
        bus(1'b0, OSC_CTRL_IDX, 32'h0, rd);
        check(rd, 32'h1, "disable bit readback");
        step(120);
        check(32'(BACKUP_OSC_ENABLE), 32'h1, "no backup");
        bus(1'b0, OPT_STAT_IDX, 32'h0, rd);
        check(rd & 32'hffff_fff7, 32'h11, "status word");
        bus(1'b1, 8'h10, 32'hffff_ffff, rd);
        bus(1'b0, 8'h10, 32'h0, rd);
        check(rd, 32'h0, "unmapped read");
        bus(1'b1, OSC_CTRL_IDX, 32'h0, rd);
        step(120);
        check(32'(BACKUP_OSC_ENABLE), 32'h0, "backup still on");
        check(32'(MAIN_OSC_ENABLE), 32'h1, "main not restarted");
    endtask : osc_switch

    // Crystal far above the ceiling: only every fourth cycle may tick
    task automatic spike_filter();
        int ticks;
        ticks = 0;
        @(posedge CLOCK);
        fast <= 1'b1;
        step(8);
        repeat (40) begin
            step(1);
            ticks += INT_CLOCK_TICK;
        end
        check(ticks, 40 / (int'(SAFEGUARD_GAP) + 1), "spikes");
        @(posedge CLOCK);
        fast <= 1'b0;
        step(16);
    endtask : spike_filter

    // Mid-run reset with the option removed and no crystal: no clock at all
    task automatic no_safeguard();
        logic [31:0] rd;
        @(posedge CLOCK);
        option <= 1'b0;
        osc_power <= 1'b0;
        RSTN <= 1'b0;
        step(3);
        @(posedge CLOCK);
        RSTN <= 1'b1;
        step(2);
        check(32'(CORE_RESET & NMI_MODE), 32'h1, "reset after release");
        step(200);
        check(32'(BACKUP_OSC_ENABLE), 32'h0, "backup w/o option");
        check(32'(CORE_RESET), 32'h1, "left reset unclocked");
        bus(1'b0, OPT_STAT_IDX, 32'h0, rd);
        check(rd, 32'h0000_000c, "status without option");
    endtask : no_safeguard

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // Power-on with a late crystal, software switch, pin and watchdog resets
    initial begin
        repeat (6) @(posedge CLOCK);
        RSTN <= 1'b1;
        run_reset(2, 200);
        osc_switch();
        spike_filter();
        run_reset(0, 0);
        run_reset(1, 0);
        no_safeguard();
        conclude();
    end

    // Whole run needs about 50k cycles
    initial begin
        #800us;
        n_mismatch++;
        conclude();
    end
endmodule : testbench
`default_nettype wire
